// ===== hw/usb_iface_manager_defines.svh
`ifndef UIMR_DEFINES_SVH
`define UIMR_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define UIMR_OFF_RESET   8'h00
`define UIMR_OFF_MCTRL   8'h04
`define UIMR_OFF_DADDR   8'h08
`define UIMR_OFF_FCTRL   8'h0c
`define UIMR_OFF_DRCTRL  8'h10
`define UIMR_OFF_DRFLAGS 8'h14
`define UIMR_OFF_SERIAL  8'h18
`define UIMR_OFF_FLAGS   8'h1c
`define UIMR_OFF_STICKY  8'h20
`define UIMR_OFF_PMASK   8'h24
`define UIMR_OFF_SOF     8'h28
`define UIMR_OFF_PID     8'h2c
`define UIMR_OFF_EP      8'h30
`define UIMR_OFF_EPMATCH 8'h34
`define UIMR_OFF_DRMASK  8'h38
`define UIMR_OFF_PWRSIG  8'h3c
`define UIMR_OFF_PHYCTRL 8'h40

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define UIMR_FLG_TOKEN 6
`define UIMR_FLG_SE0   5
`define UIMR_FLG_K     4
`define UIMR_FLG_J     3
`define UIMR_FLG_CRC16 2
`define UIMR_FLG_RXACT 1
`define UIMR_FLG_RXERR 0
`define UIMR_MCTRL_MASK 8'hf7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define UIMR_RST_FCTRL  5'h07
`define UIMR_RST_SERIAL 4'h2

`endif

// ===== hw/usb_iface_manager_pkg.sv
package uimr_pkg;
    // line state coding on the transceiver status pins
    typedef enum logic [1:0] {
        UIMR_LS_SE0 = 2'h0,
        UIMR_LS_J   = 2'h1,
        UIMR_LS_K   = 2'h2,
        UIMR_LS_SE1 = 2'h3
    } uimr_line_state_t;
endpackage : uimr_pkg

// ===== hw/usb_iface_manager_regs.sv
`timescale 1ns/100ps
`include "usb_iface_manager_defines.svh"

module uimr_regs (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // peripheral register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    // transceiver status
    input  wire logic [1:0]  line_state,
    input  wire logic        rx_active,
    input  wire logic        rx_error,
    input  wire logic        sess_end,
    input  wire logic        sess_valid,
    input  wire logic        vbus_valid,
    input  wire logic        host_disc,
    input  wire logic        id_gnd,
    input  wire logic        b_valid,
    input  wire logic        rx_dp,
    input  wire logic        rx_dm,
    input  wire logic        rx_rcv,
    // packet decoder events
    input  wire logic        token_done,
    input  wire logic        token_crc5_ok,
    input  wire logic        token_pid_ok,
    input  wire logic [6:0]  token_addr,
    input  wire logic        data_crc16_bad,
    // transceiver control
    output logic [2:0]       op_mode,
    output logic             term_select,
    output logic             xcvr_select,
    output logic             id_pin_pullup,
    output logic             dp_pulldown,
    output logic             dm_pulldown,
    output logic             dischrg_vbus,
    output logic             chrg_vbus,
    output logic             ext_vbus_drive,
    output logic             ext_vbus_indicator_sel,
    output logic             tx_se0,
    output logic             tx_data,
    output logic             tx_enable_n,
    output logic             fsls_serial,
    // manager enables
    output logic             token_process_mode,
    output logic             token_check_mode,
    output logic             line_decoder_en,
    output logic             iface_timing_en,
    output logic             power_signal_en,
    output logic             frame_start_as_token,
    output logic             event_ack_mode,
    // token acceptance and flag ports
    output logic             token_accept,
    output logic [3:0]       flag_port
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic        [7:0]  mctrl_ff;
    logic        [6:0]  dev_addr_ff;
    logic        [4:0]  fctrl_ff;
    logic        [7:0]  drctrl_ff;
    logic        [3:0]  serial_ff;
    logic        [6:0]  line_event_flags_ff;
    logic        [6:0]  flag_stickiness_reg_ff;
    logic        [31:0] pmask_ff;
    logic        [10:0] sof_ff;
    logic        [6:0]  nxt_flags;
    logic        [6:0]  flag_src;
    logic               mgr_rst;
    logic               pkt_start;
    logic               rx_active_d_ff;
    logic               tok_ok;
    // write strobes, one per writable offset
    logic               wr_reset;
    logic               wr_mctrl;
    logic               wr_daddr;
    logic               wr_fctrl;
    logic               wr_drctrl;
    logic               wr_serial;
    logic               wr_flags;
    logic               wr_sticky;
    logic               wr_pmask;
    logic               wr_sof;

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    // reset and control offsets
    assign wr_reset  = reg_wr && reg_addr == `UIMR_OFF_RESET;
    assign wr_mctrl  = reg_wr && reg_addr == `UIMR_OFF_MCTRL;
    assign wr_daddr  = reg_wr && reg_addr == `UIMR_OFF_DADDR;
    assign wr_fctrl  = reg_wr && reg_addr == `UIMR_OFF_FCTRL;
    assign wr_drctrl = reg_wr && reg_addr == `UIMR_OFF_DRCTRL;
    assign wr_serial = reg_wr && reg_addr == `UIMR_OFF_SERIAL;

    // flag, mask and counter offsets
    assign wr_flags  = reg_wr && reg_addr == `UIMR_OFF_FLAGS;
    assign wr_sticky = reg_wr && reg_addr == `UIMR_OFF_STICKY;
    assign wr_pmask  = reg_wr && reg_addr == `UIMR_OFF_PMASK;
    assign wr_sof    = reg_wr && reg_addr == `UIMR_OFF_SOF;

    // any write to offset zero acts as a manager reset
    assign mgr_rst = srst | wr_reset;

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    // manager enables
    always_ff @(posedge clk) begin
        if (mgr_rst)
            mctrl_ff <= 8'h00;
        else if (wr_mctrl)
            mctrl_ff <= reg_wdata[7:0] & `UIMR_MCTRL_MASK;
    end

    // device address
    always_ff @(posedge clk) begin
        if (mgr_rst)
            dev_addr_ff <= 7'h00;
        else if (wr_daddr)
            dev_addr_ff <= reg_wdata[6:0];
    end

    // functional control
    always_ff @(posedge clk) begin
        if (mgr_rst)
            fctrl_ff <= `UIMR_RST_FCTRL;
        else if (wr_fctrl)
            fctrl_ff <= reg_wdata[4:0];
    end

    // dual-role control, bit 5 reserved
    always_ff @(posedge clk) begin
        if (mgr_rst)
            drctrl_ff <= 8'h00;
        else if (wr_drctrl)
            drctrl_ff <= reg_wdata[7:0] & 8'hdf;
    end

    // serial control, transmit enable idles high
    always_ff @(posedge clk) begin
        if (mgr_rst)
            serial_ff <= `UIMR_RST_SERIAL;
        else if (wr_serial)
            serial_ff <= reg_wdata[3:0];
    end

    // stickiness mask
    always_ff @(posedge clk) begin
        if (mgr_rst)
            flag_stickiness_reg_ff <= 7'h00;
        else if (wr_sticky)
            flag_stickiness_reg_ff <= reg_wdata[6:0];
    end

    // port masks
    always_ff @(posedge clk) begin
        if (mgr_rst)
            pmask_ff <= 32'h0000_0000;
        else if (wr_pmask)
            pmask_ff <= reg_wdata;
    end

    // frame counter
    always_ff @(posedge clk) begin
        if (mgr_rst)
            sof_ff <= 11'h000;
        else if (wr_sof)
            sof_ff <= reg_wdata[10:0];
    end

    // ------------------------------------------------------------------
    // flags
    // ------------------------------------------------------------------
    // token passes crc, pid and address checks
    assign tok_ok = token_done && token_crc5_ok && token_pid_ok
                    && token_addr == dev_addr_ff;

    // receive-active rising edge marks a new packet
    always_ff @(posedge clk) begin
        if (mgr_rst)
            rx_active_d_ff <= 1'b0;
        else
            rx_active_d_ff <= rx_active;
    end
    assign pkt_start = rx_active & ~rx_active_d_ff;

    // event sources for each flag
    always_comb begin
        flag_src = 7'h00;
        flag_src[`UIMR_FLG_TOKEN] = tok_ok;
        flag_src[`UIMR_FLG_SE0] = mctrl_ff[2]
            && line_state == uimr_pkg::UIMR_LS_SE0;
        flag_src[`UIMR_FLG_K] = mctrl_ff[2]
            && line_state == uimr_pkg::UIMR_LS_K;
        flag_src[`UIMR_FLG_J] = mctrl_ff[2]
            && line_state == uimr_pkg::UIMR_LS_J;
        flag_src[`UIMR_FLG_CRC16] = data_crc16_bad;
        flag_src[`UIMR_FLG_RXACT] = rx_active;
        flag_src[`UIMR_FLG_RXERR] = rx_error;
    end

    // per-bit next value: sticky holds, normal bits 0-1 follow their source, bits 2-6 set on source and clear on packet start
    always_comb begin
        nxt_flags = line_event_flags_ff;
        for (int i = 0; i < 7; i++) begin
            if (flag_stickiness_reg_ff[i]) begin
                if (wr_flags && reg_wdata[i])
                    nxt_flags[i] = 1'b0;
                if (flag_src[i])
                    nxt_flags[i] = 1'b1; // set wins over clear
            end else if (i <= 1) begin
                nxt_flags[i] = flag_src[i];
            end else begin
                if (pkt_start)
                    nxt_flags[i] = 1'b0;
                if (flag_src[i])
                    nxt_flags[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (mgr_rst)
            line_event_flags_ff <= 7'h00;
        else
            line_event_flags_ff <= nxt_flags;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // or-masked flag port lines
    always_ff @(posedge clk) begin
        if (mgr_rst)
            flag_port <= 4'h0;
        else begin
            flag_port[0] <= |(nxt_flags & pmask_ff[6:0]);
            flag_port[1] <= |(nxt_flags & pmask_ff[14:8]);
            flag_port[2] <= |(nxt_flags & pmask_ff[22:16]);
            flag_port[3] <= |(nxt_flags & pmask_ff[30:24]);
        end
    end

    // token forwarding pulse
    always_ff @(posedge clk) begin
        if (mgr_rst)
            token_accept <= 1'b0;
        else
            token_accept <= tok_ok & mctrl_ff[0];
    end

    // registered control outputs, one cycle after the register
    always_ff @(posedge clk) begin
        if (srst) begin
            op_mode              <= 3'h1;
            term_select          <= 1'b1;
            xcvr_select          <= 1'b1;
            {ext_vbus_indicator_sel, ext_vbus_drive} <= 2'h0;
            {chrg_vbus, dischrg_vbus, dm_pulldown} <= 3'h0;
            {dp_pulldown, id_pin_pullup} <= 2'h0;
            {tx_se0, tx_data, fsls_serial} <= 3'h0;
            tx_enable_n          <= 1'b1;
            {event_ack_mode, frame_start_as_token} <= 2'h0;
            {power_signal_en, iface_timing_en} <= 2'h0;
            {line_decoder_en, token_check_mode} <= 2'h0;
            token_process_mode   <= 1'b0;
        end else begin
            op_mode              <= fctrl_ff[4:2];
            term_select          <= fctrl_ff[1];
            xcvr_select          <= fctrl_ff[0];
            ext_vbus_indicator_sel <= drctrl_ff[7];
            ext_vbus_drive       <= drctrl_ff[6];
            chrg_vbus            <= drctrl_ff[4];
            dischrg_vbus         <= drctrl_ff[3];
            dm_pulldown          <= drctrl_ff[2];
            dp_pulldown          <= drctrl_ff[1];
            id_pin_pullup        <= drctrl_ff[0];
            tx_se0               <= serial_ff[3];
            tx_data              <= serial_ff[2];
            tx_enable_n          <= serial_ff[1];
            fsls_serial          <= serial_ff[0];
            event_ack_mode       <= mctrl_ff[7];
            frame_start_as_token <= mctrl_ff[6];
            power_signal_en      <= mctrl_ff[5];
            iface_timing_en      <= mctrl_ff[4];
            line_decoder_en      <= mctrl_ff[2];
            token_check_mode     <= mctrl_ff[1];
            token_process_mode   <= mctrl_ff[0];
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    // registered read data, unmapped and write-only offsets read zero
    always_ff @(posedge clk) begin
        if (srst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd) begin
            unique case (reg_addr)
                `UIMR_OFF_MCTRL:   reg_rdata <= {24'h0, mctrl_ff};
                `UIMR_OFF_DADDR:   reg_rdata <= {25'h0, dev_addr_ff};
                `UIMR_OFF_FCTRL:   reg_rdata <= {27'h0, fctrl_ff};
                `UIMR_OFF_DRCTRL:  reg_rdata <= {24'h0, drctrl_ff};
                `UIMR_OFF_DRFLAGS: reg_rdata <= {26'h0, b_valid, id_gnd,
                    host_disc, vbus_valid, sess_valid, sess_end};
                `UIMR_OFF_SERIAL:  reg_rdata <= {25'h0, rx_rcv, rx_dm,
                    rx_dp, serial_ff};
                `UIMR_OFF_FLAGS:   reg_rdata <= {25'h0, line_event_flags_ff};
                `UIMR_OFF_STICKY:  reg_rdata <= {25'h0,
                    flag_stickiness_reg_ff};
                `UIMR_OFF_PMASK:   reg_rdata <= pmask_ff;
                `UIMR_OFF_SOF:     reg_rdata <= {21'h0, sof_ff};
                default:           reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : uimr_regs

// ===== bench/uimr_xcvr_model.sv
`timescale 1ns/100ps
module uimr_xcvr_model (
    // clock
    input  wire logic clk,
    // transceiver status lines
    output logic [1:0] line_state,
    output logic [1:0] rx_lines,
    output logic [5:0] otg,
    output logic [2:0] sense,
    // packet decoder events
    output logic       tdone,
    output logic       c5ok,
    output logic       pidok,
    output logic [6:0] taddr,
    output logic       cbad
);
    // idle: line parked at se1, no events pending
    initial begin
        {line_state, rx_lines, otg, sense} = {2'h3, 11'h000};
        {tdone, c5ok, pidok, taddr, cbad} = 11'h000;
    end
    // new levels on the status lines just after an edge
    task automatic st(input logic [1:0] ls, input logic [1:0] rx,
                      input logic [5:0] o, input logic [2:0] s);
        @(posedge clk);
        #1;
        {line_state, rx_lines, otg, sense} = {ls, rx, o, s};
    endtask : st
    // one decoder event for one edge; qualifiers flip once it is gone
    task automatic ev(input logic t, c, p, b, input logic [6:0] a);
        @(posedge clk);
        #1;
        {tdone, c5ok, pidok, taddr, cbad} = {t, c, p, a, b};
        @(posedge clk);
        #1;
        {tdone, c5ok, pidok, taddr, cbad} = {1'b0, ~c, ~p, ~a, 1'b0};
    endtask : ev
endmodule : uimr_xcvr_model

// ===== bench/uimr_regs_monitor.sv
`timescale 1ns/100ps
module uimr_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // register port
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    // decoder events
    input wire logic        token_done,
    input wire logic        token_crc5_ok,
    input wire logic        token_pid_ok,
    input wire logic [6:0]  token_addr,
    // watched outputs
    input wire logic [2:0]  op_mode,
    input wire logic        tx_enable_n,
    input wire logic        token_process_mode,
    input wire logic        token_accept
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic [6:0] dev_ff;
    logic [4:0] wlo;
    logic       wr0, tok_ok;
    logic       en_ff;
    // decode of port values
    assign wr0 = reg_wr && reg_addr == 8'h00;
    assign wlo = reg_wdata[4:0];
    assign tok_ok = token_done && token_crc5_ok && token_pid_ok
                    && token_addr == dev_ff && en_ff;
    // shadow of the stored device address
    always_ff @(posedge clk) begin
        if (srst || wr0) dev_ff <= 7'h00;
        else if (reg_wr && reg_addr == 8'h08) dev_ff <= reg_wdata[6:0];
    end
    // shadow of the token processing enable, same edge as the register
    always_ff @(posedge clk) begin
        if (srst || wr0) en_ff <= 1'b0;
        else if (reg_wr && reg_addr == 8'h04) en_ff <= reg_wdata[0];
    end
    reset_out_a: assert property ($fell(srst) |->
        op_mode == 3'h1 && tx_enable_n && !token_accept)
        else $error("outputs wrong after reset");
    fctrl_drive_a: assert property (reg_wr && reg_addr == 8'h0c |->
        ##2 {op_mode, 2'b00} == ($past(wlo, 2) & 5'h1c))
        else $error("op mode differs from write");
    tx_enable_a: assert property (reg_wr && reg_addr == 8'h18 |->
        ##2 tx_enable_n == |($past(wlo, 2) & 5'h02))
        else $error("transmit enable differs from write");
    state_reset_a: assert property (wr0 |-> ##2 op_mode == 3'h1
        && tx_enable_n && !token_process_mode)
        else $error("state not reset by write");
    tok_accept_a: assert property (tok_ok |=> token_accept)
        else $error("good token not accepted");
    no_stray_a: assert property (token_accept |-> $past(tok_ok))
        else $error("token accepted without cause");
    rdata_hold_a: assert property (!reg_rd && !wr0 && !$past(wr0)
        |=> $stable(reg_rdata)) else $error("read data moved");
    unmapped_zero_a: assert property (reg_rd && (reg_addr == 8'h00
        || reg_addr > 8'h28) |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    cover property (token_accept);
    cover property (wr0);
    cover property (reg_rd && reg_addr == 8'h1c);
endmodule : uimr_monitor

// ===== bench/usb_iface_manager_regs_tb.sv
`timescale 1ns/100ps
module usb_iface_manager_regs_tb;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [1:0]  ls, rx;
    logic [2:0]  sns, opm;
    logic [3:0]  txo, fp;
    logic [5:0]  otg;
    logic [6:0]  ta, drc, men;
    logic        td, c5, pk, cb, ts, xs, tacc;
    logic [23:0] outs;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cyc = 0;
    // block under test, outputs gathered into vectors
    uimr_regs DUT (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .line_state(ls), .rx_active(rx[1]), .rx_error(rx[0]),
        .sess_end(otg[0]), .sess_valid(otg[1]), .vbus_valid(otg[2]),
        .host_disc(otg[3]), .id_gnd(otg[4]), .b_valid(otg[5]),
        .rx_dp(sns[0]), .rx_dm(sns[1]), .rx_rcv(sns[2]), .token_done(td),
        .token_crc5_ok(c5), .token_pid_ok(pk), .token_addr(ta),
        .data_crc16_bad(cb), .op_mode(opm), .term_select(ts),
        .xcvr_select(xs), .id_pin_pullup(drc[0]), .dp_pulldown(drc[1]),
        .dm_pulldown(drc[2]), .dischrg_vbus(drc[3]), .chrg_vbus(drc[4]),
        .ext_vbus_drive(drc[5]), .ext_vbus_indicator_sel(drc[6]),
        .tx_se0(txo[3]), .tx_data(txo[2]), .tx_enable_n(txo[1]),
        .fsls_serial(txo[0]), .token_process_mode(men[0]),
        .token_check_mode(men[1]), .line_decoder_en(men[2]),
        .iface_timing_en(men[3]), .power_signal_en(men[4]),
        .frame_start_as_token(men[5]), .event_ack_mode(men[6]),
        .token_accept(tacc), .flag_port(fp));
    // transceiver and decoder model
    uimr_xcvr_model x (.clk(clk), .line_state(ls), .rx_lines(rx), .otg(otg),
        .sense(sns), .tdone(td), .c5ok(c5), .pidok(pk), .taddr(ta), .cbad(cb));
    // every control output side by side, for one compare
    assign outs = {opm, ts, xs, drc, men, txo, tacc};
    // 25 MHz clock
    always #20 clk = ~clk;
    // hang guard, far beyond the length of the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // compare and count
    task automatic chk(input string nm, input logic [31:0] got, e);
        tests_run++;
        if (got !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, got);
        end
    endtask : chk
    // one register access, held until the taking edge
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, ~w, a, d};
        @(posedge clk);
        #1;
        {reg_wr, reg_rd} = 2'b00;
    endtask : acc
    // read and compare
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), reg_rdata, e);
    endtask : rc
    // reset values of registers and outputs
    task automatic t_def();
        logic [7:0]  a[10] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                               8'h1c, 8'h20, 8'h24, 8'h28};
        logic [31:0] v;
        foreach (a[i]) begin
            v = a[i] == 8'h0c ? 32'h7 : 32'h0;
            rc(a[i], a[i] == 8'h18 ? 32'h2 : v);
        end
        chk("outputs", 32'(outs), 32'h380004);
    endtask : t_def
    // all ones written, reserved and read-only bits dropped
    task automatic t_rw();
        logic [7:0]  a[10] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                               8'h20, 8'h28, 8'h2c, 8'h80};
        logic [11:0] e[10] = '{12'h0f7, 12'h07f, 12'h01f, 12'h0df, 12'h000,
                               12'h00f, 12'h07f, 12'h7ff, 12'h000, 12'h000};
        foreach (a[i]) acc(1'b1, a[i], 32'hffffffff);
        foreach (a[i]) rc(a[i], 32'(e[i]));
        chk("outputs", 32'(outs), 32'hfffffe);
        acc(1'b1, 8'h00, 32'h5a5a5a5a);
        t_def();
    endtask : t_rw
    // live transceiver inputs
    task automatic t_live();
        x.st(2'h3, 2'h0, 6'h2a, 3'h5);
        rc(8'h14, 32'h2a);
        rc(8'h18, 32'h52);
        x.st(2'h3, 2'h0, 6'h15, 3'h2);
        rc(8'h14, 32'h15);
        rc(8'h18, 32'h22);
    endtask : t_live
    // token filter: {crc5 ok, pid ok, address, accepted}
    task automatic t_tok();
        logic [9:0] tk[5] = '{10'h301, 10'h32b, 10'h328, 10'h12a, 10'h22a};
        acc(1'b1, 8'h04, 32'h1);
        foreach (tk[i]) begin
            if (i == 1) acc(1'b1, 8'h08, 32'h15);
            x.ev(1'b1, tk[i][9], tk[i][8], 1'b0, tk[i][7:1]);
            chk("accept", 32'(tacc), 32'(tk[i][0]));
        end
        rc(8'h1c, 32'h40);
    endtask : t_tok
    // flags, stickiness and port masks
    task automatic t_flags();
        acc(1'b1, 8'h04, 32'h5);
        acc(1'b1, 8'h20, 32'h4);
        acc(1'b1, 8'h24, 32'h02041040);
        x.st(2'h2, 2'h0, 6'h0, 3'h0);
        x.st(2'h3, 2'h0, 6'h0, 3'h0);
        x.ev(1'b1, 1'b1, 1'b1, 1'b1, 7'h15);
        rc(8'h1c, 32'h54);
        chk("port", 32'(fp), 32'h7);
        x.st(2'h3, 2'h2, 6'h0, 3'h0);
        rc(8'h1c, 32'h06);
        chk("port", 32'(fp), 32'hc);
        acc(1'b1, 8'h1c, 32'h4);
        rc(8'h1c, 32'h02);
        x.st(2'h0, 2'h1, 6'h0, 3'h0);
        x.st(2'h1, 2'h1, 6'h0, 3'h0);
        x.st(2'h3, 2'h1, 6'h0, 3'h0);
        rc(8'h1c, 32'h29);
        x.st(2'h3, 2'h2, 6'h0, 3'h0);
        rc(8'h1c, 32'h02);
    endtask : t_flags
    // counts and verdict
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        #1;
        srst = 1'b0;
        t_def();
        t_rw();
        t_live();
        t_tok();
        t_flags();
        end_of_test();
    end
endmodule : usb_iface_manager_regs_tb
bind uimr_regs uimr_monitor MON (.clk(clk), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .token_done(token_done),
    .token_crc5_ok(token_crc5_ok), .token_pid_ok(token_pid_ok),
    .token_addr(token_addr), .op_mode(op_mode), .tx_enable_n(tx_enable_n),
    .token_process_mode(token_process_mode), .token_accept(token_accept));
